// >>> perf_monitor_pkg.sv
// Constants for the monitor control register and its trigger logic
`default_nettype none
package perf_monitor_pkg;
  // Special register numbers
  localparam logic [9:0] SPR_CONTROL_ZERO = 10'h3B8;
  localparam logic [9:0] SPR_USER_MIRROR  = 10'h3A8;
  // Field positions, big-endian bit 0 is the msb of the word
  localparam int FC_POS        = 31 - 0;
  localparam int EXC_ENABLE_POS   = 31 - 5;
  localparam int FREEZE_EVENT_POS = 31 - 6;
  localparam int TB_EVENT_POS     = 31 - 9;
  localparam int P1CE_POS      = 31 - 16;
  localparam int PJCE_POS      = 31 - 17;
  localparam int TRIGGER_POS   = 31 - 18;
  localparam int SEL1_LSB      = 31 - 25;
  localparam int SEL1_W        = 7;
  localparam int SEL2_LSB      = 31 - 31;
  localparam int SEL2_W        = 6;
  // Reset value
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> perf_neg_detect.sv
// Counter negative detect and enabled-condition combiner
`timescale 1ns/1ps
`default_nettype none
module perf_neg_detect #(
  parameter int NUM_CNT = 4,
  parameter int CNT_W   = 32
) (
  // Counter values
  input  wire logic [NUM_CNT*CNT_W-1:0] cnt_values,
  // Enables
  input  wire logic                     first_counter_negative_enable,
  input  wire logic                     other_counter_negative_enable,
  // Results
  output logic                          first_negative,
  output logic                          enabled_negative
);
  logic [NUM_CNT-1:0] neg;  // Msb of each counter
  // Negative means most significant bit set
  genvar g;
  for (g = 0; g < NUM_CNT; g++) begin : g_neg
    assign neg[g] = cnt_values[g*CNT_W + CNT_W-1];
  end
  assign first_negative = neg[0];
  // Other counters act as conditions only when enabled
  assign enabled_negative = (first_counter_negative_enable & neg[0])
                          | (other_counter_negative_enable & (|neg[NUM_CNT-1:1]));
endmodule
`default_nettype wire

// >>> perf_monitor_trigger_control.sv
// Monitor control register zero, user mirror and trigger hold logic
`timescale 1ns/1ps
`default_nettype none
module perf_monitor_trigger_control #(
  parameter int NUM_CNT = 4,
  parameter int CNT_W   = 32
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Special register move port
  input  wire logic                     spr_write,
  input  wire logic                     spr_read,
  input  wire logic [9:0]               spr_num,
  input  wire logic [31:0]              spr_wdata,
  output logic [31:0]                   spr_rdata,
  output logic                          spr_hit,
  // Counter values and events
  input  wire logic [NUM_CNT*CNT_W-1:0] cnt_values,
  input  wire logic                     timebase_event,
  input  wire logic                     monitor_interrupt,
  // Controls to the counters
  output logic                          first_counter_inc_enable,
  output logic                          other_counter_inc_enable,
  output logic [6:0]                    first_counter_event_select,
  output logic [5:0]                    second_counter_event_select,
  output logic [31:0]                   monitor_control_zero
);
  // Refuse sizes that the negative detect and the field packing cannot serve
  if (NUM_CNT < 2 || CNT_W < 2) begin : g_bad_size
    $error("Need at least two counters of two bits");
  end

  ////////////////////////////////////////////////////////////////////////
  // Condition detection
  logic first_negative;    // First counter msb
  logic enabled_negative;  // Enabled counter negative condition
  logic enabled_event;     // Any enabled condition or event

  perf_neg_detect #(.NUM_CNT(NUM_CNT), .CNT_W(CNT_W)) u_neg (
    .cnt_values                    (cnt_values),
    .first_counter_negative_enable (monitor_control_zero[perf_monitor_pkg::P1CE_POS]),
    .other_counter_negative_enable (monitor_control_zero[perf_monitor_pkg::PJCE_POS]),
    .first_negative                (first_negative),
    .enabled_negative              (enabled_negative)
  );

  assign enabled_event = enabled_negative
                       | (timebase_event & monitor_control_zero[perf_monitor_pkg::TB_EVENT_POS]);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0] ctrl_reg;     // Control register zero
  logic [31:0] ctrl_next;
  logic [31:0] rdata_reg;    // Read data
  logic [31:0] rdata_next;
  logic        hit_reg;      // Access matched a register
  logic        hit_next;
  logic        inc1_reg;     // First counter permission
  logic        inc1_next;
  logic        incj_reg;     // Other counter permission
  logic        incj_next;
  logic        release_now;  // Trigger release this cycle

  assign release_now = ctrl_reg[perf_monitor_pkg::TRIGGER_POS]
                     & (first_negative | enabled_event);

  // Next values of the control register and outputs
  always_comb begin
    ctrl_next = ctrl_reg;
    // Software write to the control number only; mirror ignores writes
    if (spr_write && spr_num == perf_monitor_pkg::SPR_CONTROL_ZERO) begin
      ctrl_next = spr_wdata;
    end
    // Freeze on event only when not triggered
    if (enabled_event && ctrl_reg[perf_monitor_pkg::FREEZE_EVENT_POS]
        && !ctrl_reg[perf_monitor_pkg::TRIGGER_POS]) begin
      ctrl_next[perf_monitor_pkg::FC_POS] = 1'b1;
    end
    // Hardware clear of trigger wins over software write
    if (release_now) begin
      ctrl_next[perf_monitor_pkg::TRIGGER_POS] = 1'b0;
    end
    // Interrupt taken clears exception enable
    if (monitor_interrupt && ctrl_reg[perf_monitor_pkg::EXC_ENABLE_POS]) begin
      ctrl_next[perf_monitor_pkg::EXC_ENABLE_POS] = 1'b0;
    end
    // Read mux, both numbers show the control register
    rdata_next = 32'h0000_0000;
    hit_next   = 1'b0;
    if (spr_read && (spr_num == perf_monitor_pkg::SPR_CONTROL_ZERO
                     || spr_num == perf_monitor_pkg::SPR_USER_MIRROR)) begin
      rdata_next = ctrl_reg;
      hit_next   = 1'b1;
    end
    if (spr_write && spr_num == perf_monitor_pkg::SPR_CONTROL_ZERO) begin
      hit_next = 1'b1;
    end
    // Counting permissions
    inc1_next = !ctrl_next[perf_monitor_pkg::FC_POS];
    incj_next = !ctrl_next[perf_monitor_pkg::FC_POS]
              && !ctrl_next[perf_monitor_pkg::TRIGGER_POS];
  end

  // Register everything
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg  <= perf_monitor_pkg::CONTROL_RESET;
      rdata_reg <= 32'h0000_0000;
      hit_reg   <= 1'b0;
      inc1_reg  <= 1'b1;
      incj_reg  <= 1'b1;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      hit_reg   <= hit_next;
      inc1_reg  <= inc1_next;
      incj_reg  <= incj_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign monitor_control_zero        = ctrl_reg;
  assign spr_rdata                   = rdata_reg;
  assign spr_hit                     = hit_reg;
  assign first_counter_inc_enable    = inc1_reg;
  assign other_counter_inc_enable    = incj_reg;
  assign first_counter_event_select  =
    ctrl_reg[perf_monitor_pkg::SEL1_LSB +: perf_monitor_pkg::SEL1_W];
  assign second_counter_event_select =
    ctrl_reg[perf_monitor_pkg::SEL2_LSB +: perf_monitor_pkg::SEL2_W];

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_trig_cond;
    ctrl_reg[perf_monitor_pkg::TRIGGER_POS] && (first_negative || enabled_event);
  endsequence

  a_trigger_release: assert property (@(posedge clk) disable iff (!arst_n)
    s_trig_cond |=> !ctrl_reg[perf_monitor_pkg::TRIGGER_POS] && incj_reg
                    == !ctrl_reg[perf_monitor_pkg::FC_POS])
    else $error("Trigger not released on condition");
  a_trigger_hold: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_reg[perf_monitor_pkg::TRIGGER_POS] |-> !incj_reg)
    else $error("Other counters ran while triggered");
  a_untriggered_run: assert property (@(posedge clk) disable iff (!arst_n)
    !ctrl_reg[perf_monitor_pkg::TRIGGER_POS] && !ctrl_reg[perf_monitor_pkg::FC_POS]
    |-> incj_reg && inc1_reg)
    else $error("Counting held without trigger");
  a_first_select: assert property (@(posedge clk) disable iff (!arst_n)
    first_counter_event_select == monitor_control_zero[12:6])
    else $error("First select field misplaced");
  a_second_select: assert property (@(posedge clk) disable iff (!arst_n)
    second_counter_event_select == monitor_control_zero[5:0])
    else $error("Second select field misplaced");
  a_mirror_read: assert property (@(posedge clk) disable iff (!arst_n)
    spr_read && spr_num == perf_monitor_pkg::SPR_USER_MIRROR |=> spr_rdata == $past(ctrl_reg))
    else $error("Mirror read mismatch");
  a_mirror_nowrite: assert property (@(posedge clk) disable iff (!arst_n)
    spr_write && spr_num == perf_monitor_pkg::SPR_USER_MIRROR && !release_now
    && !monitor_interrupt && !enabled_event |=> $stable(ctrl_reg))
    else $error("Mirror accepted a write");
  a_ctrl_write: assert property (@(posedge clk) disable iff (!arst_n)
    spr_write && spr_num == perf_monitor_pkg::SPR_CONTROL_ZERO && !release_now
    && !monitor_interrupt && !enabled_event |=> ctrl_reg == $past(spr_wdata))
    else $error("Control write lost");
  a_exc_en_clear: assert property (@(posedge clk) disable iff (!arst_n)
    monitor_interrupt && ctrl_reg[perf_monitor_pkg::EXC_ENABLE_POS]
    |=> !ctrl_reg[perf_monitor_pkg::EXC_ENABLE_POS])
    else $error("Exception enable not cleared");
  a_no_freeze_trig: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_reg[perf_monitor_pkg::TRIGGER_POS] && !ctrl_reg[perf_monitor_pkg::FC_POS] && !spr_write
    |=> !ctrl_reg[perf_monitor_pkg::FC_POS])
    else $error("Froze while triggered");

  ////////////////////////////////////////////////////////////////////////
  // Freeze, release sources and access answers
  // Enabled condition with freeze armed while no trigger is pending
  sequence s_freeze_cond;
    enabled_event && ctrl_reg[perf_monitor_pkg::FREEZE_EVENT_POS]
    && !ctrl_reg[perf_monitor_pkg::TRIGGER_POS];
  endsequence

  // Freeze stops both counter groups one cycle after the condition
  a_freeze_untrig: assert property (@(posedge clk) disable iff (!arst_n)
    s_freeze_cond |=> ctrl_reg[perf_monitor_pkg::FC_POS]
                      && !first_counter_inc_enable && !other_counter_inc_enable)
    else $error("Counters not frozen on enabled condition");

  // First counter msb alone releases the trigger, whatever its enable
  a_first_msb_release: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_reg[perf_monitor_pkg::TRIGGER_POS] && cnt_values[CNT_W-1]
    |=> !ctrl_reg[perf_monitor_pkg::TRIGGER_POS])
    else $error("First counter msb did not release trigger");

  // Second counter negative is a release condition once enabled
  a_other_neg_cond: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_reg[perf_monitor_pkg::TRIGGER_POS] && ctrl_reg[perf_monitor_pkg::PJCE_POS]
    && cnt_values[2*CNT_W-1] |=> !ctrl_reg[perf_monitor_pkg::TRIGGER_POS])
    else $error("Enabled other counter did not release trigger");

  // With no release source and no write the trigger keeps holding
  a_trigger_stays: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_reg[perf_monitor_pkg::TRIGGER_POS] && !cnt_values[CNT_W-1] && !enabled_event
    && !spr_write |=> ctrl_reg[perf_monitor_pkg::TRIGGER_POS])
    else $error("Trigger dropped without a condition");

  // A write to the control number is answered with a hit
  a_write_hit: assert property (@(posedge clk) disable iff (!arst_n)
    spr_write && spr_num == perf_monitor_pkg::SPR_CONTROL_ZERO |=> spr_hit)
    else $error("Control write not acknowledged");

  // A read of the mirror number is answered with a hit
  a_mirror_hit: assert property (@(posedge clk) disable iff (!arst_n)
    spr_read && spr_num == perf_monitor_pkg::SPR_USER_MIRROR |=> spr_hit)
    else $error("Mirror read not acknowledged");
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the monitor control register and trigger hold logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Clock, reset and bench counters
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  int           err_count = 0;
  int           n_tests = 0;
  // Register move port
  logic         spr_write = 1'b0;
  logic         spr_read = 1'b0;
  logic [9:0]   spr_num = 10'h000;
  logic [31:0]  spr_wdata = 32'h0000_0000;
  logic [31:0]  spr_rdata;
  logic         spr_hit;
  // Counters, events and controls
  logic [127:0] cnt_values = 128'h0;
  logic         timebase_event = 1'b0;
  logic         monitor_interrupt = 1'b0;
  logic         first_counter_inc_enable;
  logic         other_counter_inc_enable;
  logic [6:0]   first_counter_event_select;
  logic [5:0]   second_counter_event_select;
  logic [31:0]  monitor_control_zero;
  // Field masks of the control word
  localparam logic [31:0] TRG = 32'h1 << perf_monitor_pkg::TRIGGER_POS;
  localparam logic [31:0] FC  = 32'h1 << perf_monitor_pkg::FC_POS;
  localparam logic [31:0] OCE = 32'h1 << perf_monitor_pkg::PJCE_POS;
  localparam logic [31:0] FEV = 32'h1 << perf_monitor_pkg::FREEZE_EVENT_POS;
  localparam logic [31:0] TBE = 32'h1 << perf_monitor_pkg::TB_EVENT_POS;
  localparam logic [31:0] EXE = 32'h1 << perf_monitor_pkg::EXC_ENABLE_POS;

  always #10 clk = ~clk;

  perf_monitor_trigger_control dut (
    .clk(clk), .arst_n(arst_n), .spr_write(spr_write), .spr_read(spr_read),
    .spr_num(spr_num), .spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .spr_hit(spr_hit),
    .cnt_values(cnt_values), .timebase_event(timebase_event),
    .monitor_interrupt(monitor_interrupt),
    .first_counter_inc_enable(first_counter_inc_enable),
    .other_counter_inc_enable(other_counter_inc_enable),
    .first_counter_event_select(first_counter_event_select),
    .second_counter_event_select(second_counter_event_select),
    .monitor_control_zero(monitor_control_zero));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, count and report a mismatch at once
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    n_tests++;
    if (act !== exp) begin
      err_count++;
      $display("ERROR t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  // One register write, control word settled on return
  task automatic spr_wr(input logic [9:0] num, input logic [31:0] d);
    @(posedge clk);
    spr_write <= 1'b1;
    spr_num   <= num;
    spr_wdata <= d;
    @(posedge clk);
    spr_write <= 1'b0;
    #1;
  endtask
  // One register read, answer taken in its single valid cycle
  task automatic spr_rd(input logic [9:0] num, output logic [31:0] d, output logic h);
    @(posedge clk);
    spr_read <= 1'b1;
    spr_num  <= num;
    @(posedge clk);
    spr_read <= 1'b0;
    #1;
    d = spr_rdata;
    h = spr_hit;
  endtask
  // Drive the counters, then let one sampling edge pass
  task automatic set_cnt(input logic [127:0] v);
    @(posedge clk);
    cnt_values <= v;
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset state, field selects, mirror and unmapped access
  task automatic t_regs();
    logic [31:0] d;
    logic        h;
    logic [31:0] v;
    spr_rd(10'h3B8, d, h);
    chk(d, 32'h0000_0000);
    chk({31'h0, h}, 32'h1);
    chk({30'h0, first_counter_inc_enable, other_counter_inc_enable}, 32'h3);
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 32'h0000_156A : 32'h0000_1FFF; // Mixed and all-ones selects
      spr_wr(10'h3B8, v);
      chk({31'h0, spr_hit}, 32'h1);
      chk({25'h0, first_counter_event_select}, {25'h0, v[12:6]});
      chk({26'h0, second_counter_event_select}, {26'h0, v[5:0]});
      spr_rd(10'h3B8, d, h);
      chk(d, v);
      spr_rd(10'h3A8, d, h);
      chk(d, v);
      chk({31'h0, h}, 32'h1);
    end
    spr_wr(10'h3A8, 32'hFFFF_FFFF);
    chk(monitor_control_zero, v);
    chk({31'h0, spr_hit}, 32'h0);
    spr_rd(10'h3B9, d, h);
    chk(d, 32'h0000_0000);
    chk({31'h0, h}, 32'h0);
    $display("test regs done");
  endtask
  // Trigger hold and release by first counter going negative
  task automatic t_trigger();
    spr_wr(10'h3B8, TRG);
    chk({30'h0, first_counter_inc_enable, other_counter_inc_enable}, 32'h2);
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, other_counter_inc_enable}, 32'h0);
    set_cnt(128'h8000_0000);
    chk(monitor_control_zero & TRG, 32'h0);
    chk({31'h0, other_counter_inc_enable}, 32'h1);
    set_cnt(128'h0);
    $display("test trigger done");
  endtask
  // Trigger then freeze setup, conditions, masking and time base release
  task automatic t_cond();
    spr_wr(10'h3B8, TRG | OCE | FEV);
    set_cnt(128'h8000_0000);
    chk(monitor_control_zero & (TRG | FC), 32'h0);
    chk({31'h0, other_counter_inc_enable}, 32'h1);
    set_cnt({64'h0, 32'h8000_0000, 32'h8000_0000});
    chk(monitor_control_zero & FC, FC);
    chk({30'h0, first_counter_inc_enable, other_counter_inc_enable}, 32'h0);
    set_cnt(128'h0);
    spr_wr(10'h3B8, TRG | OCE | FEV);
    set_cnt({64'h0, 32'h8000_0000, 32'h0});
    chk(monitor_control_zero & (TRG | FC), 32'h0);
    @(posedge clk);
    #1;
    chk(monitor_control_zero & FC, FC);
    set_cnt(128'h0);
    spr_wr(10'h3B8, TRG | TBE);
    @(posedge clk);
    timebase_event <= 1'b1;
    @(posedge clk);
    timebase_event <= 1'b0;
    #1;
    chk(monitor_control_zero & TRG, 32'h0);
    spr_wr(10'h3B8, TRG);
    set_cnt({64'h0, 32'h8000_0000, 32'h0});
    chk(monitor_control_zero & TRG, TRG);
    chk({31'h0, other_counter_inc_enable}, 32'h0);
    set_cnt(128'h0);
    $display("test conditions done");
  endtask
  // Trigger with interrupt setup, then interrupt clears only the exception enable
  task automatic t_irq();
    spr_wr(10'h3B8, TRG | EXE | 32'h0000_002A);
    set_cnt(128'h8000_0000);
    chk(monitor_control_zero, EXE | 32'h0000_002A);
    chk({30'h0, first_counter_inc_enable, other_counter_inc_enable}, 32'h3);
    set_cnt(128'h0);
    @(posedge clk);
    monitor_interrupt <= 1'b1;
    @(posedge clk);
    monitor_interrupt <= 1'b0;
    #1;
    chk(monitor_control_zero, 32'h0000_002A);
    $display("test interrupt done");
  endtask
  // Reset in mid-run returns the register and permissions to their reset state
  task automatic t_rst();
    logic [31:0] d;
    logic        h;
    spr_wr(10'h3B8, TRG | FC | 32'h0000_156A);
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(monitor_control_zero, perf_monitor_pkg::CONTROL_RESET);
    chk({30'h0, first_counter_inc_enable, other_counter_inc_enable}, 32'h3);
    @(posedge clk);
    arst_n <= 1'b1;
    spr_rd(10'h3B8, d, h);
    chk(d, perf_monitor_pkg::CONTROL_RESET);
    $display("test reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_trigger();
    t_cond();
    t_irq();
    t_rst();
    final_report();
  end
  // Watchdog, far beyond the roughly 70 cycles the tests take
  initial begin
    #50000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
